// ---- rtl/bfcr_top.sv ----
`default_nettype none

module bfcr_top (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        cpu_req,
  input  wire logic        cpu_we,
  input  wire logic [31:0] cpu_addr,
  input  wire logic [31:0] cpu_wdata,
  output logic             cpu_done,
  output logic [31:0]      cpu_rdata,
  input  wire logic        cpu_resume,
  output logic             fault_irq,
  input  wire logic        io_sel,
  input  wire logic        io_wr,
  input  wire logic        io_wide,
  input  wire logic [31:0] io_addr,
  input  wire logic [31:0] io_wdata,
  output logic [31:0]      io_rdata,
  input  wire logic [31:0] local_addr_data_bus_in,
  output logic [31:0]      local_addr_data_bus_out,
  output logic             local_addr_data_bus_oe,
  input  wire logic        local_ready_in,
  input  wire logic        fault_code_in
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------
  // save registers
  // ----------------------------------------
  bfcr_save_if save ();

  bfcr_save_regs u_save (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .io_sel   (io_sel),
    .io_wr    (io_wr),
    .io_wide  (io_wide),
    .io_addr  (io_addr),
    .io_wdata (io_wdata),
    .io_rdata (io_rdata),
    .bus      (save.store)
  );

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  bfcr_pkg::bfcr_phase_t phase;
  bfcr_pkg::bfcr_phase_t next_phase;
  bfcr_pkg::bfcr_phase_t saved_phase;
  logic        we;
  logic [31:0] addr_q;
  logic [31:0] data_q;

  wire         in_bus    = (phase == bfcr_pkg::BFCR_ADDR) | (phase == bfcr_pkg::BFCR_DATA);
  wire         complete  = in_bus & local_ready_in;
  wire         faulted   = complete & fault_code_in;
  wire         ok        = complete & ~fault_code_in;
  wire [31:0]  bus_now   = local_addr_data_bus_oe ? local_addr_data_bus_out : local_addr_data_bus_in;
  wire         halted    = phase == bfcr_pkg::BFCR_HALT;
  wire         abort_req = save.state == bfcr_pkg::STATE_ABRT;
  wire         saved_we  = save.state[bfcr_pkg::ST_WRITE_BIT];
  wire         saved_ok  = (saved_phase == bfcr_pkg::BFCR_ADDR) | (saved_phase == bfcr_pkg::BFCR_DATA);
  wire         resume_go = halted & cpu_resume & ~abort_req & saved_ok;
  wire         resume_ab = halted & cpu_resume & ~resume_go;

  assign saved_phase = bfcr_pkg::bfcr_phase_t'(save.state[bfcr_pkg::ST_PHASE_LSB +: 2]);

  assign save.capture  = faulted;
  assign save.cap_data = bus_now;
  assign save.cap_state = {11'h000, we, 2'h0, phase};

  always_comb begin
    next_phase = phase;
    case (phase)
      bfcr_pkg::BFCR_IDLE: if (cpu_req) next_phase = bfcr_pkg::BFCR_ADDR;
      bfcr_pkg::BFCR_ADDR: if (faulted) next_phase = bfcr_pkg::BFCR_HALT;
                           else if (ok) next_phase = bfcr_pkg::BFCR_DATA;
      bfcr_pkg::BFCR_DATA: if (faulted) next_phase = bfcr_pkg::BFCR_HALT;
                           else if (ok) next_phase = bfcr_pkg::BFCR_IDLE;
      bfcr_pkg::BFCR_HALT: if (resume_go) next_phase = saved_phase;
                           else if (resume_ab) next_phase = bfcr_pkg::BFCR_IDLE;
      default:             next_phase = bfcr_pkg::BFCR_IDLE;
    endcase
  end

  // ----------------------------------------
  // access sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= bfcr_pkg::BFCR_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      we                      <= 1'b0;
      addr_q                  <= 32'h0000_0000;
      data_q                  <= 32'h0000_0000;
      local_addr_data_bus_out <= 32'h0000_0000;
      local_addr_data_bus_oe  <= 1'b0;
      cpu_done                <= 1'b0;
      cpu_rdata               <= 32'h0000_0000;
      fault_irq               <= 1'b0;
    end else begin
      cpu_done  <= 1'b0;
      fault_irq <= faulted;
      if (phase == bfcr_pkg::BFCR_IDLE && cpu_req) begin
        we                      <= cpu_we;
        addr_q                  <= cpu_addr;
        data_q                  <= cpu_wdata;
        local_addr_data_bus_out <= cpu_addr;
        local_addr_data_bus_oe  <= 1'b1;
      end else if (faulted) begin
        local_addr_data_bus_oe <= 1'b0;
      end else if (ok && phase == bfcr_pkg::BFCR_ADDR) begin
        local_addr_data_bus_out <= data_q;
        local_addr_data_bus_oe  <= we;
      end else if (ok) begin
        local_addr_data_bus_oe <= 1'b0;
        cpu_done               <= 1'b1;
        cpu_rdata              <= local_addr_data_bus_in;
      end else if (resume_go) begin
        we                      <= saved_we;
        local_addr_data_bus_out <= save.data;
        local_addr_data_bus_oe  <= (saved_phase == bfcr_pkg::BFCR_ADDR) | saved_we;
        if (saved_phase == bfcr_pkg::BFCR_DATA) data_q <= save.data;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_SAVE_BUS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    faulted |=> save.data == $past(bus_now))
    else $error("bus value not saved on fault");
  AST_SAVE_STATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    faulted |=> save.state == {11'h000, $past(we), 2'h0, $past(phase)})
    else $error("controller state not saved on fault");
  AST_NOTIFY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    faulted |=> fault_irq ##1 !fault_irq)
    else $error("fault notice not a single pulse");
  AST_KIND_POINT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    faulted |=> save.state[bfcr_pkg::ST_WRITE_BIT] == $past(we) && halted)
    else $error("saved access kind wrong");
  AST_RESTORE_BUS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (resume_go && saved_phase == bfcr_pkg::BFCR_ADDR) |=> local_addr_data_bus_oe
      && local_addr_data_bus_out == $past(save.data))
    else $error("saved bus value not driven on resume");
  AST_RESTORE_PHASE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    resume_go |=> phase == $past(saved_phase))
    else $error("phase not reloaded on resume");
  AST_READ_SAVED: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (faulted && !local_addr_data_bus_oe) |=> save.data == $past(local_addr_data_bus_in))
    else $error("read fault did not save bus value");
  AST_ABORT_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (halted && cpu_resume && abort_req) |=> phase == bfcr_pkg::BFCR_IDLE && !local_addr_data_bus_oe
      ##1 !cpu_done)
    else $error("abort did not go idle");
  AST_NO_EXT_CYCLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    faulted |=> !local_addr_data_bus_oe throughout (halted [*2]))
    else $error("bus driven while halted on fault");
  AST_ADDR_ON_BUS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (phase == bfcr_pkg::BFCR_ADDR) |-> local_addr_data_bus_oe && local_addr_data_bus_out == addr_q)
    else $error("address not driven in address phase");
  AST_WRITE_ON_BUS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (phase == bfcr_pkg::BFCR_DATA && we) |-> local_addr_data_bus_oe && local_addr_data_bus_out == data_q)
    else $error("write data not driven in data phase");
  AST_READ_RELEASED: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (phase == bfcr_pkg::BFCR_DATA && !we) |-> !local_addr_data_bus_oe)
    else $error("bus driven in read data phase");
  AST_HALT_WAITS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (halted && !cpu_resume) |=> halted)
    else $error("left halt without resume");
  AST_IRQ_CAUSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fault_irq |-> $past(faulted) && halted)
    else $error("fault notice without a fault");
  AST_READ_RESULT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ok && phase == bfcr_pkg::BFCR_DATA) |=> cpu_done && cpu_rdata == $past(local_addr_data_bus_in))
    else $error("completion result wrong");
  AST_DONE_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cpu_done |=> !cpu_done)
    else $error("done longer than one cycle");
  AST_IDLE_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (phase == bfcr_pkg::BFCR_IDLE) |-> !local_addr_data_bus_oe)
    else $error("bus driven while idle");
  AST_REQ_IGNORED: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (halted && cpu_req && !cpu_resume) |=> halted && !local_addr_data_bus_oe)
    else $error("request taken while halted");

  COV_READ_FAULT:  cover property (@(posedge sys_clk) disable iff (!rst_n) faulted && !we);
  COV_WRITE_FAULT: cover property (@(posedge sys_clk) disable iff (!rst_n) faulted && we);
  COV_RESUME:      cover property (@(posedge sys_clk) disable iff (!rst_n) resume_go ##[1:20] cpu_done);
  COV_ABORT:       cover property (@(posedge sys_clk) disable iff (!rst_n) resume_ab);
  COV_ADDR_RESUME: cover property (@(posedge sys_clk) disable iff (!rst_n) resume_go && saved_phase == bfcr_pkg::BFCR_ADDR);
endmodule

`default_nettype wire

// ---- rtl/bfcr_pkg.sv ----
`default_nettype none

package bfcr_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;

  // ----------------------------------------
  // register addresses
  // ----------------------------------------
  localparam logic [31:0] ADDR_STATE     = 32'hC000_02D0;
  localparam logic [31:0] ADDR_DATA_LOW  = 32'hC000_0320;
  localparam logic [31:0] ADDR_DATA_HIGH = 32'hC000_0330;

  // ----------------------------------------
  // reset values and special codes
  // ----------------------------------------
  localparam logic [31:0] DATA_RST   = 32'h0000_0000;
  localparam logic [15:0] STATE_RST  = 16'h0000;
  localparam logic [15:0] STATE_ABRT = 16'hFFFF;

  // ----------------------------------------
  // state register fields
  // ----------------------------------------
  localparam int ST_PHASE_LSB = 0;
  localparam int ST_WRITE_BIT = 4;

  typedef enum logic [1:0] {
    BFCR_IDLE = 2'h0,
    BFCR_ADDR = 2'h1,
    BFCR_DATA = 2'h3,
    BFCR_HALT = 2'h2
  } bfcr_phase_t;
endpackage

`default_nettype wire

// ---- rtl/bfcr_save_if.sv ----
`default_nettype none

interface bfcr_save_if;
  logic        capture;
  logic [31:0] cap_data;
  logic [15:0] cap_state;
  logic [31:0] data;
  logic [15:0] state;

  modport ctrl  (output capture, output cap_data, output cap_state, input data, input state);
  modport store (input capture, input cap_data, input cap_state, output data, output state);
endinterface

`default_nettype wire

// ---- rtl/bfcr_save_regs.sv ----
`default_nettype none

module bfcr_save_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        io_sel,
  input  wire logic        io_wr,
  input  wire logic        io_wide,
  input  wire logic [31:0] io_addr,
  input  wire logic [31:0] io_wdata,
  output var  logic [31:0] io_rdata,
  bfcr_save_if.store       bus
);
  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic hit(input logic [31:0] a, input logic [31:0] t);
    return a == t;
  endfunction

  logic [31:0] data_reg;
  logic [15:0] state_reg;
  logic [31:0] next_rdata;
  wire         hit_state = io_sel & hit(io_addr, bfcr_pkg::ADDR_STATE);
  wire         hit_low   = io_sel & hit(io_addr, bfcr_pkg::ADDR_DATA_LOW);
  wire         hit_high  = io_sel & hit(io_addr, bfcr_pkg::ADDR_DATA_HIGH) & ~io_wide;
  wire         wr_low    = io_wr & hit_low;
  wire         wr_high   = io_wr & (hit_high | (hit_low & io_wide));
  wire         wr_state  = io_wr & hit_state;

  assign next_rdata = hit_low   ? (io_wide ? data_reg : {16'h0000, data_reg[15:0]}) :
                      hit_high  ? {16'h0000, data_reg[31:16]} :
                      hit_state ? {16'h0000, state_reg} : 32'h0000_0000;

  assign bus.data  = data_reg;
  assign bus.state = state_reg;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // capture wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg  <= bfcr_pkg::DATA_RST;
      state_reg <= bfcr_pkg::STATE_RST;
      io_rdata  <= 32'h0000_0000;
    end else begin
      io_rdata <= (io_sel & ~io_wr) ? next_rdata : 32'h0000_0000;
      if (bus.capture) begin
        data_reg  <= bus.cap_data;
        state_reg <= bus.cap_state;
      end else begin
        if (wr_low) data_reg[15:0] <= io_wdata[15:0];
        if (wr_high) data_reg[31:16] <= io_wide ? io_wdata[31:16] : io_wdata[15:0];
        if (wr_state) state_reg <= io_wdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_CAPTURE_OVERWRITES: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus.capture |=> data_reg == $past(bus.cap_data) && state_reg == $past(bus.cap_state))
    else $error("capture did not overwrite saved values");
  AST_READ_HIGH_HALF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (hit_high & ~io_wr & ~bus.capture) |=> io_rdata == {16'h0000, $past(data_reg[31:16])})
    else $error("high half read wrong");
  AST_READ_WORD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (hit_low & io_wide & ~io_wr) |=> io_rdata == $past(data_reg))
    else $error("32-bit read wrong");
endmodule

`default_nettype wire

// ---- verification/bfcr_mem_model.sv ----
`default_nettype none

module bfcr_mem_model (
  input  wire logic   sys_clk,
  output logic [31:0] bus_in,
  output logic        ready,
  output logic        fault
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    bus_in = 32'h0000_0000;
    ready = 1'b0;
    fault = 1'b0;
  end

  // ----------------------------------------
  // completions, one per phase
  // ----------------------------------------
  // released bus shows the inverse, not the old value
  task automatic serve(input int n, input int fi, input int dly, input logic [31:0] val);
    for (int i = 0; i < n; i++) begin
      repeat (dly) @(negedge sys_clk);
      ready <= 1'b1;
      fault <= (i == fi);
      bus_in <= val;
      @(negedge sys_clk);
      ready <= 1'b0;
      fault <= 1'b0;
      bus_in <= ~val;
    end
  endtask
endmodule

`default_nettype wire

// ---- verification/bfcr_bench.sv ----
`default_nettype none

module bfcr_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        sys_clk, resetn, cpu_req, cpu_we, cpu_resume, io_sel, io_wr, io_wide;
  logic [31:0] cpu_addr, cpu_wdata, io_addr, io_wdata;
  logic        cpu_done, fault_irq, bus_oe, ready, fault, rd_taken;
  logic [31:0] cpu_rdata, io_rdata, bus_out, bus_in;
  logic [32:0] dq[$];
  logic [31:0] rq[$];
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          seed = 32'h647F4691;

  bfcr_top DUT (.sys_clk(sys_clk), .resetn(resetn), .cpu_req(cpu_req), .cpu_we(cpu_we),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_done(cpu_done), .cpu_rdata(cpu_rdata),
    .cpu_resume(cpu_resume), .fault_irq(fault_irq), .io_sel(io_sel), .io_wr(io_wr),
    .io_wide(io_wide), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .local_addr_data_bus_in(bus_in), .local_addr_data_bus_out(bus_out),
    .local_addr_data_bus_oe(bus_oe), .local_ready_in(ready), .fault_code_in(fault));

  bfcr_mem_model MEM (.sys_clk(sys_clk), .bus_in(bus_in), .ready(ready), .fault(fault));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic cmpv(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_done;
    logic [32:0] e;
    if (dq.size() == 0) cmpv(cpu_rdata, ~cpu_rdata);
    else begin
      e = dq.pop_front();
      if (e[32]) cmpv(cpu_rdata, e[31:0]);
    end
  endtask

  task automatic cmp_reg;
    if (rq.size() == 0) cmpv(io_rdata, ~io_rdata);
    else cmpv(io_rdata, rq.pop_front());
  endtask

  task automatic stop_test;
    $display("counts: cmp_count=%0d n_mismatch=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge sys_clk) rd_taken <= io_sel && !io_wr;

  always @(negedge sys_clk) begin
    if (cpu_done === 1'b1) cmp_done();
    if (rd_taken === 1'b1) cmp_reg();
  end

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic wait_hi(input logic irq);
    int k;
    k = 0;
    while ((irq ? fault_irq : cpu_done) !== 1'b1 && k < 60) begin
      @(negedge sys_clk);
      k++;
    end
    if (k == 60) begin
      n_mismatch++;
      stop_test();
    end
  endtask

  task automatic access(input logic we, input logic [31:0] a, input logic [31:0] d);
    cpu_we = we;
    cpu_addr = a;
    cpu_wdata = d;
    cpu_req = 1'b1;
    @(negedge sys_clk);
    cpu_req = 1'b0;
  endtask

  task automatic io(input logic wr, input logic wide, input logic [31:0] a, input logic [31:0] d,
                    input logic [31:0] e);
    io_wr = wr;
    io_wide = wide;
    io_addr = a;
    io_wdata = d;
    io_sel = 1'b1;
    if (!wr) rq.push_back(e);
    @(negedge sys_clk);
    io_sel = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic plain(input logic we);
    logic [31:0] v;
    v = $random(seed);
    dq.push_back({!we, v});
    fork MEM.serve(2, -1, 1 + $unsigned($random(seed)) % 3, v); join_none
    access(we, $random(seed), $random(seed));
    wait_hi(1'b0);
    $display("plain access done we=%0d", we);
  endtask

  task automatic fault_case(input logic we, input int fi, input logic abort);
    logic [31:0] a, d, v, sv;
    a = $random(seed);
    d = $random(seed);
    v = $random(seed);
    sv = fi == 0 ? a : (we ? d : v);
    io(1'b1, 1'b1, bfcr_pkg::ADDR_DATA_LOW, ~sv, 32'h0);
    fork MEM.serve(fi + 1, fi, 1 + $unsigned($random(seed)) % 3, v); join_none
    access(we, a, d);
    wait_hi(1'b1);
    cmpv({31'h0, bus_oe}, 32'h0);
    io(1'b0, 1'b1, bfcr_pkg::ADDR_DATA_LOW, 32'h0, sv);
    io(1'b0, 1'b0, bfcr_pkg::ADDR_DATA_LOW, 32'h0, {16'h0, sv[15:0]});
    io(1'b0, 1'b0, bfcr_pkg::ADDR_DATA_HIGH, 32'h0, {16'h0, sv[31:16]});
    io(1'b0, 1'b0, bfcr_pkg::ADDR_STATE, 32'h0, {27'h0, we, 2'h0, fi ? 2'h3 : 2'h1});
    if (abort) io(1'b1, 1'b0, bfcr_pkg::ADDR_STATE, 32'h0000_FFFF, 32'h0);
    cpu_resume = 1'b1;
    if (!abort) begin
      dq.push_back({!we, v});
      fork MEM.serve(2 - fi, -1, 1, v); join_none
    end
    @(negedge sys_clk);
    cpu_resume = 1'b0;
    if (abort) cmpv({31'h0, bus_oe}, 32'h0);
    else cmpv({31'h0, bus_oe}, {31'h0, fi == 0 || we});
    if (!abort && (fi == 0 || we)) cmpv(bus_out, fi == 0 ? a : d);
    if (abort) repeat (8) @(negedge sys_clk);
    else wait_hi(1'b0);
    $display("fault case done we=%0d phase=%0d abort=%0d", we, fi, abort);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    {cpu_req, cpu_we, cpu_resume, io_sel, io_wr, io_wide} = 6'h00;
    {cpu_addr, cpu_wdata, io_addr, io_wdata} = 128'h0;
    repeat (3) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    plain(1'b0);
    plain(1'b1);
    for (int k = 0; k < 4; k++) fault_case(k[0], k >> 1, 1'b0);
    fault_case(1'b1, 1, 1'b1);
    fault_case(1'b0, 0, 1'b1);
    plain(1'b0);
    io(1'b0, 1'b1, bfcr_pkg::ADDR_DATA_HIGH, 32'h0, 32'h0);
    io(1'b0, 1'b0, 32'hC000_0340, 32'h0, 32'h0);
    $display("register map test done");
    repeat (3) @(negedge sys_clk);
    stop_test();
  end
endmodule

`default_nettype wire
